// *** logic/dit_pkg.sv ***
// Purpose: shared constants and types for the dac i2c target interface
// Assumes: 20 MHz system clock, bus sampled by that clock
// Notes: register contents behind the command byte live outside this block
package dit_pkg;
  localparam logic [3:0] ADDR_FIXED_HI = 4'h9;
  localparam logic [6:0] ADDR_BROADCAST = 7'h47;
  localparam logic [7:0] GCALL_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GCALL_RESET_BYTE = 8'h06;
  localparam logic [2:0] SEL_AGND = 3'h0;
  localparam logic [2:0] SEL_VDD = 3'h1;
  localparam logic [2:0] SEL_SDA = 3'h2;
  localparam logic [2:0] SEL_SCL = 3'h3;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BUS_MAX_HZ = 1000000;
  localparam int unsigned SAMPLES_PER_BIT = CLK_HZ / BUS_MAX_HZ;

  typedef struct packed {
    logic scl;
    logic sda;
  } dit_bus_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } dit_write_t;
endpackage

// *** logic/dit_bus_sync.sv ***
// Purpose: two-flop synchroniser and condition detector for scl, sda and the select pin
// Assumes: inputs are asynchronous to clk
// Notes: the first flop stage feeds only the second; edge and condition logic compares the second stage with a third
`timescale 1ns/1ps
module dit_bus_sync
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sel_in,
  output dit_pkg::dit_bus_t bus_now,
  output logic sel_now,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  dit_pkg::dit_bus_t meta_reg;
  dit_pkg::dit_bus_t sync_reg;
  dit_pkg::dit_bus_t last_reg;
  logic sel_meta_reg;
  logic sel_sync_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
      last_reg <= '1;
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= '{scl: scl_in, sda: sda_in};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      sel_meta_reg <= sel_in;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  assign bus_now = sync_reg;
  assign sel_now = sel_sync_reg;
  assign scl_rise = sync_reg.scl & ~last_reg.scl;
  assign scl_fall = ~sync_reg.scl & last_reg.scl;
  // sda moving while scl stays high marks a bus condition
  assign start_seen = sync_reg.scl & last_reg.scl & last_reg.sda & ~sync_reg.sda;
  assign stop_seen = sync_reg.scl & last_reg.scl & ~last_reg.sda & sync_reg.sda;
endmodule

// *** logic/dit_target.sv ***
// Purpose: i2c target front end of a quad dac: address match, command, two data bytes
// Assumes: 20 MHz clk, bus at most 1 Mbps, register file outside answers rd_data
// Notes: sda is open drain: sda_out is always low, sda_oe pulls the line
//
// Contract
// - only seven-bit addresses decoded; ten-bit headers never match
// - general call 0x00 then 0x06 then stop performs software reset
// - software reset asserted at rising scl of acknowledge after 0x06
// - ninth clock carries acknowledge: sda low through high phase
// - start is sda falling while scl high, detected by device
// - stop is sda rising while scl high; release bus, await start
// - transmitter changes sda only while scl is low
// - acknowledge address byte only when address matches own, broadcast write or general call
// - receiver acknowledges each byte; device on writes, master on reads
// - data moves in nine-bit units, as many as master wants
// - device acknowledges every received byte in its ack high phase
// - byte after address is command selecting target register
// - update fires on falling scl of acknowledge after lower byte
// - upper four address bits are fixed 1001
// - low address bits from select pin: agnd, vdd, sda, scl
// - select pin sampled during first byte of frame and latched
// - broadcast address 1000111 with write direction also accepted
// - broadcast never answered for reads
// - same protocol at 100 kbps, 400 kbps and 1 Mbps
// - read: write address and command, repeated start, return upper, lower
// - read without command returns last written register
`timescale 1ns/1ps
module dit_target
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_select_pin,
  output logic sda_out,
  output logic sda_oe,
  output logic sw_reset,
  output logic wr_valid,
  output dit_pkg::dit_write_t wr_word,
  output logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data
);
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ = 5'h08,
    ST_SKIP = 5'h10
  } dit_state_t;

  dit_pkg::dit_bus_t bus_now;
  logic sel_now;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  dit_state_t state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_reg;
  logic [7:0] cmd_reg;
  logic [7:0] upper_data_byte;
  logic [7:0] last_cmd_reg;
  logic [15:0] tx_reg;
  logic ack_pend_reg;
  logic master_nack_reg;
  logic gcall_reg;
  logic gcall_armed_reg;
  logic sel_seen_low_reg;
  logic sel_seen_high_reg;
  logic sel_follow_sda_reg;
  logic sel_follow_scl_reg;
  logic [2:0] low_addr_reg;
  logic [2:0] low_addr_next;

  dit_bus_sync u_sync
  (
    .clk(clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sel_in(addr_select_pin),
    .bus_now(bus_now),
    .sel_now(sel_now),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // own address: fixed high nibble, three low bits from the select pin
  function automatic logic own_match(input logic [6:0] a, input logic [2:0] low);
    own_match = (a[6:3] == dit_pkg::ADDR_FIXED_HI[3:0]) && (a[2:0] == low);
  endfunction

  // general call, own address and broadcast writes answered in the address slot; broadcast is refused for reads
  function automatic logic addr_accept(input logic [7:0] b, input logic [2:0] low);
    addr_accept = (b == dit_pkg::GCALL_ADDR_BYTE) || own_match(b[7:1], low) ||
      (!b[0] && b[7:1] == dit_pkg::ADDR_BROADCAST);
  endfunction

  // the select pin tied to sda or scl follows that line; tied high or low it is static
  always_comb
  begin
    if (sel_follow_scl_reg)
      low_addr_next = dit_pkg::SEL_SCL;
    else if (sel_follow_sda_reg)
      low_addr_next = dit_pkg::SEL_SDA;
    else if (sel_seen_high_reg)
      low_addr_next = dit_pkg::SEL_VDD;
    else
      low_addr_next = dit_pkg::SEL_AGND;
  end

  // select pin classification over the address byte
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sel_seen_low_reg <= 1'b0;
      sel_seen_high_reg <= 1'b0;
      sel_follow_sda_reg <= 1'b1;
      sel_follow_scl_reg <= 1'b1;
      low_addr_reg <= 3'h0;
    end
    else if (start_seen)
    begin
      sel_seen_low_reg <= 1'b0;
      sel_seen_high_reg <= 1'b0;
      sel_follow_sda_reg <= 1'b1;
      sel_follow_scl_reg <= 1'b1;
    end
    else if (state_reg == ST_ADDR && bit_reg < dit_pkg::BIT_ACK)
    begin
      // sampled at the scl rising edge, with sda settled since the low phase
      if (scl_rise)
      begin
        if (sel_now)
          sel_seen_high_reg <= 1'b1;
        else
          sel_seen_low_reg <= 1'b1;
        if (sel_now != bus_now.sda)
          sel_follow_sda_reg <= 1'b0;
      end
      if (scl_fall && sel_now)
        sel_follow_scl_reg <= 1'b0;
      if (scl_rise && !sel_now)
        sel_follow_scl_reg <= 1'b0;
    end
    else if (state_reg == ST_ADDR && bit_reg == dit_pkg::BIT_ACK)
      low_addr_reg <= low_addr_next;
  end

  // bit counter and receive shifter: nine-bit units, msb first
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (start_seen)
      bit_reg <= 4'hf; // the start's own scl fall then lands on bit zero
    else if (scl_rise && bit_reg < dit_pkg::BIT_ACK)
      shift_reg <= {shift_reg[6:0], bus_now.sda};
    else if (scl_fall && state_reg != ST_IDLE && state_reg != ST_SKIP)
      bit_reg <= (bit_reg == dit_pkg::BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
  end

  // protocol state, byte position and received fields
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      byte_reg <= 2'h0;
      cmd_reg <= 8'h00;
      upper_data_byte <= 8'h00;
      last_cmd_reg <= 8'h00;
      ack_pend_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      gcall_reg <= 1'b0;
      gcall_armed_reg <= 1'b0;
    end
    else if (start_seen)
    begin
      state_reg <= ST_ADDR;
      byte_reg <= 2'h0;
      ack_pend_reg <= 1'b0;
      gcall_reg <= 1'b0;
      gcall_armed_reg <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_reg <= ST_IDLE;
      ack_pend_reg <= 1'b0;
      gcall_armed_reg <= 1'b0;
    end
    else if (scl_fall && bit_reg == 4'h7)
    begin
      // eighth bit done: decide whether the ack slot is ours
      case (state_reg)
        ST_ADDR:
        begin
          if (shift_reg == dit_pkg::GCALL_ADDR_BYTE)
          begin
            gcall_reg <= 1'b1;
            ack_pend_reg <= 1'b1;
          end
          else if (shift_reg[0] == 1'b0 &&
            (own_match(shift_reg[7:1], low_addr_next) ||
             shift_reg[7:1] == dit_pkg::ADDR_BROADCAST))
            ack_pend_reg <= 1'b1;
          else if (shift_reg[0] == 1'b1 && own_match(shift_reg[7:1], low_addr_next))
            ack_pend_reg <= 1'b1;
          else
            ack_pend_reg <= 1'b0;
        end
        ST_WRITE:
        begin
          ack_pend_reg <= 1'b1;
          if (gcall_reg)
            gcall_armed_reg <= (shift_reg == dit_pkg::GCALL_RESET_BYTE);
          else if (byte_reg == 2'h0)
            cmd_reg <= shift_reg;
          else if (byte_reg == 2'h1)
            upper_data_byte <= shift_reg;
        end
        default:
          ack_pend_reg <= 1'b0;
      endcase
    end
    else if (scl_rise && bit_reg == dit_pkg::BIT_ACK && state_reg == ST_READ)
      master_nack_reg <= bus_now.sda;
    else if (scl_fall && bit_reg == dit_pkg::BIT_ACK)
    begin
      ack_pend_reg <= 1'b0;
      case (state_reg)
        ST_ADDR:
        begin
          if (!ack_pend_reg)
            state_reg <= ST_SKIP;
          else if (shift_reg[0] && !gcall_reg)
            state_reg <= ST_READ;
          else
            state_reg <= ST_WRITE;
          byte_reg <= 2'h0;
          master_nack_reg <= 1'b0;
        end
        ST_WRITE:
        begin
          if (byte_reg == 2'h0)
            last_cmd_reg <= cmd_reg;
          byte_reg <= (byte_reg == 2'h2) ? 2'h0 : byte_reg + 2'h1;
          if (byte_reg == 2'h2)
            byte_reg <= 2'h1; // further pairs reuse the same command
        end
        ST_READ:
        begin
          byte_reg <= byte_reg + 2'h1;
          if (master_nack_reg)
            state_reg <= ST_SKIP;
        end
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // read data: upper byte then lower byte, loaded at the address ack
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tx_reg <= 16'h0000;
    else if (state_reg == ST_ADDR && scl_fall && bit_reg == dit_pkg::BIT_ACK)
      tx_reg <= rd_data;
    // eight shifts per byte leave the next byte's msb in bit 15
    else if (state_reg == ST_READ && scl_fall && bit_reg < dit_pkg::BIT_ACK)
      tx_reg <= {tx_reg[14:0], 1'b0};
  end

  // sda drive set on scl falling edges; start, stop and a refused address release it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sda_oe <= 1'b0;
    else if (start_seen || stop_seen)
      sda_oe <= 1'b0;
    else if (scl_fall)
    begin
      if (bit_reg == 4'h7 && state_reg != ST_READ && state_reg != ST_SKIP)
        sda_oe <= (state_reg == ST_ADDR) ? addr_accept(shift_reg, low_addr_next)
          : (state_reg == ST_WRITE);
      else if (state_reg == ST_READ && bit_reg < 4'h7 && !master_nack_reg)
        sda_oe <= ~tx_reg[14];
      else if (state_reg == ST_READ && bit_reg == 4'h7)
        sda_oe <= 1'b0; // master owns the ack slot on reads
      else if (state_reg == ST_READ && bit_reg == dit_pkg::BIT_ACK && !master_nack_reg)
        sda_oe <= ~tx_reg[15];
      else if (state_reg == ST_ADDR && bit_reg == dit_pkg::BIT_ACK && shift_reg[0]
        && ack_pend_reg && !gcall_reg)
        sda_oe <= ~rd_data[15];
      else
        sda_oe <= 1'b0;
    end
    else if (state_reg == ST_ADDR && bit_reg == dit_pkg::BIT_ACK && !ack_pend_reg)
      sda_oe <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // write update pulse and general call reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_valid <= 1'b0;
      wr_word <= '0;
      sw_reset <= 1'b0;
      rd_cmd <= 8'h00;
    end
    else
    begin
      wr_valid <= 1'b0;
      rd_cmd <= (state_reg == ST_WRITE && byte_reg == 2'h1) ? cmd_reg : last_cmd_reg;
      if (scl_fall && bit_reg == dit_pkg::BIT_ACK && state_reg == ST_WRITE
        && byte_reg == 2'h2 && !gcall_reg)
      begin
        wr_valid <= 1'b1;
        wr_word <= '{cmd: cmd_reg, data: {upper_data_byte, shift_reg}};
      end
      // held from the ack rising edge until a stop or a start ends the sequence
      if (scl_rise && bit_reg == dit_pkg::BIT_ACK && gcall_reg && state_reg == ST_WRITE
        && gcall_armed_reg)
        sw_reset <= 1'b1;
      else if (stop_seen || start_seen)
        sw_reset <= 1'b0;
    end
  end
endmodule

// *** sim/dit_target_checker.sv ***
// Purpose: pin level checks for the i2c target
// Assumes: bus bits of at least 8 clk, scl high for 3 clk
// Notes: bound to every dit_target instance
`timescale 1ns/1ps
module dit_target_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_select_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sw_reset,
  input wire logic wr_valid,
  input dit_pkg::dit_write_t wr_word,
  input wire logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda drive moved while scl high");
  property p_ack_hold; $rose(sda_oe) |-> sda_oe [*4]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("sda drive too short");
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high");
  property p_gc_reset; $rose(sw_reset) |-> sda_oe; endproperty
  a_gc_reset: assert property (p_gc_reset)
    else $error("soft reset outside ack");
  property p_wr_fall; wr_valid |-> !scl_in && ($past(sda_oe) || $past(sda_oe, 2)); endproperty
  a_wr_fall: assert property (p_wr_fall)
    else $error("update not at ack fall");
  property p_word_hold; $changed(wr_word) |-> wr_valid; endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("write word moved without update");
  property p_wr_gap; wr_valid |=> !wr_valid [*8]; endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("updates too close");
  property p_gc_no_wr; sw_reset |-> !wr_valid; endproperty
  a_gc_no_wr: assert property (p_gc_no_wr)
    else $error("update during soft reset");
endmodule

bind dit_target dit_target_checker u_dit_target_checker (.clk(clk), .reset(reset),
  .scl_in(scl_in), .sda_in(sda_in), .addr_select_pin(addr_select_pin), .sda_out(sda_out),
  .sda_oe(sda_oe), .sw_reset(sw_reset), .wr_valid(wr_valid), .wr_word(wr_word),
  .rd_cmd(rd_cmd), .rd_data(rd_data));

// *** sim/dit_master_model.sv ***
// Purpose: behavioural i2c bus master
// Assumes: 8 clk per bit, 5 low and 3 high
// Notes: sda_drv low pulls the line, high releases to the pull-up
`timescale 1ns/1ps
module dit_master_model
(
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves mid low phase so the target sees it after its scl fall
  task automatic bit_io(input logic b, output logic r);
    wait_clk(2);
    sda_drv <= b;
    wait_clk(3);
    scl <= 1'b1;
    repeat (2) @(negedge clk);
    r = sda_wire;
    wait_clk(2);
    scl <= 1'b0;
  endtask
  // a=1 start or repeated start, a=0 stop; scl stays high after stop
  task automatic cond(input logic a);
    wait_clk(2);
    sda_drv <= a;
    wait_clk(3);
    scl <= 1'b1;
    wait_clk(2);
    sda_drv <= !a;
    wait_clk(3);
    scl <= !a;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(nack, r);
  endtask
endmodule

// *** sim/dit_target_tb_top.sv ***
// Purpose: self-checking bench for the i2c target
// Assumes: 20 MHz clk, bus bit of 400 ns from the master model
// Notes: rd_data mirrors rd_cmd so reads show which command was used
`timescale 1ns/1ps
module dit_target_tb_top;
  logic clk = 1'b0;
  logic reset;
  logic scl, m_sda, sda_wire, sda_out, sda_oe, sw_reset, wr_valid, sel_pin, k;
  logic [1:0] sel_mode;
  logic [7:0] rnd;
  logic [7:0] rd_cmd, c;
  logic [15:0] rd_data;
  logic [15:0] d;
  dit_pkg::dit_write_t wr_word, last_word;
  int error_cnt = 0;
  int n_checks;
  int wr_cnt = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  assign sda_wire = m_sda & ~(sda_oe & ~sda_out);
  assign sel_pin = sel_mode == 2'h0 ? 1'b0 : sel_mode == 2'h1 ? 1'b1 :
                   sel_mode == 2'h2 ? sda_wire : scl;
  dit_master_model u_dit_master_model (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda_drv(m_sda));
  dit_target u_dit_target (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
    .addr_select_pin(sel_pin), .sda_out(sda_out), .sda_oe(sda_oe), .sw_reset(sw_reset),
    .wr_valid(wr_valid), .wr_word(wr_word), .rd_cmd(rd_cmd), .rd_data(rd_data));
  always @(posedge clk)
  begin
    rd_data <= {rd_cmd, ~rd_cmd};
    if (wr_valid === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      last_word <= wr_word;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [6:0] own_addr(input logic [1:0] m);
    return {dit_pkg::ADDR_FIXED_HI, 1'b0, m};
  endfunction
  task automatic roll(output logic [7:0] v);
    rnd = lfsr(rnd);
    v = rnd;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a refused frame still sends all bytes: each must go unanswered
  task automatic wr_frame(input logic [6:0] a, input int pairs, input logic ok);
    int n0;
    n0 = wr_cnt;
    roll(c);
    roll(d[15:8]);
    roll(d[7:0]);
    u_dit_master_model.cond(1'b1);
    u_dit_master_model.wr_byte({a, 1'b0}, k);
    chk(24'(k), 24'(!ok));
    u_dit_master_model.wr_byte(c, k);
    chk(24'(k), 24'(!ok));
    for (int p = 0; p < pairs; p++)
    begin
      u_dit_master_model.wr_byte(d[15:8], k);
      chk(24'(k), 24'(!ok));
      u_dit_master_model.wr_byte(d[7:0], k);
      chk(24'(k), 24'(!ok));
    end
    u_dit_master_model.cond(1'b0);
    chk(24'(wr_cnt - n0), ok ? 24'(pairs) : 24'h0);
    if (ok)
      chk(last_word, {c, d});
  endtask
  task automatic rd_frame(input logic [6:0] a, input logic cmd_first, input logic [15:0] exp);
    logic [7:0] hi, lo;
    if (cmd_first)
    begin
      u_dit_master_model.cond(1'b1);
      u_dit_master_model.wr_byte({a, 1'b0}, k);
      chk(24'(k), 24'h0);
      u_dit_master_model.wr_byte(c, k);
      chk(24'(k), 24'h0);
    end
    u_dit_master_model.cond(1'b1);
    u_dit_master_model.wr_byte({a, 1'b1}, k);
    chk(24'(k), 24'h0);
    u_dit_master_model.rd_byte(1'b0, hi);
    u_dit_master_model.rd_byte(1'b1, lo);
    u_dit_master_model.cond(1'b0);
    chk({8'h0, hi, lo}, {8'h0, exp});
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    reset = 1'b1;
    sel_mode = 2'h0;
    rnd = 8'h21;
    n_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 4; m++)
    begin
      sel_mode <= 2'(m);
      wr_frame(own_addr(2'(m)), 1, 1'b1);
      wr_frame(own_addr(2'(m + 1)), 1, 1'b0);
    end
    wr_frame(7'h78, 1, 1'b0);
    wr_frame(dit_pkg::ADDR_BROADCAST, 1, 1'b1);
    wr_frame(own_addr(2'h3), 2, 1'b1);
    rd_frame(own_addr(2'h3), 1'b0, {c, ~c});
    roll(c);
    rd_frame(own_addr(2'h3), 1'b1, {c, ~c});
    u_dit_master_model.cond(1'b1);
    u_dit_master_model.wr_byte({dit_pkg::ADDR_BROADCAST, 1'b1}, k);
    chk(24'(k), 24'h1);
    u_dit_master_model.cond(1'b0);
    u_dit_master_model.cond(1'b1);
    u_dit_master_model.wr_byte(dit_pkg::GCALL_ADDR_BYTE, k);
    chk(24'(k), 24'h0);
    u_dit_master_model.wr_byte(dit_pkg::GCALL_RESET_BYTE, k);
    @(negedge clk);
    chk(24'(sw_reset), 24'h1);
    u_dit_master_model.cond(1'b0);
    repeat (4) @(negedge clk);
    chk(24'(sw_reset), 24'h0);
    end_sim();
  end
endmodule
